// ---- core/gex_core.sv ----
/*
 * Eight-bit port expander core: two-wire bus slave, register pointer,
 * four port registers and the per-pin driver control.
 * Assumes raw bus lines, straps and pins from outside the sys_clk
 * domain, a bus clock well below sys_clk/4 and an external pull-up.
 */
//
// Functional notes
// - Address is fixed nibble plus three straps
// - Last address bit one reads, zero writes
// - Byte after address is stored in pointer
// - Pointer low two bits select register
// - Pointer is never returned on reads
// - Input register shows sampled pin levels
// - Writes to input register are ignored
// - Input register has no reset default
// - Output bits drive only output pins
// - Output register reads back written value
// - Output, direction all ones; invert zero
// - Invert bit one flips reported pin value
// - Inversion applies to input pins only
// - Direction one is input, zero output
// - Output pin enables exactly one driver
// - All pins come up as inputs
// - Reset initialises registers and bus machine
// - Write accepts any number of data bytes
// - Read follows command, restart, read address
`timescale 1ns/1ns
module gex_core import gex_pkg::*; #(
    parameter logic [3:0] ADDR_UPPER = ADDR_UPPER_LOW
) (
    // Clock and power-up reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Two-wire bus, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Address straps
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    // Port pins, bit n is pin n
    input wire logic [7:0] port_pin_in,
    output logic [7:0] port_pin_out,
    output logic [7:0] port_pin_oe_n,
    output logic [7:0] high_side_driver,
    output logic [7:0] low_side_driver
);

    gex_pins_t raw;
    gex_pins_t syn;
    gex_regs_t regs_q;
    gex_state_t state_q;
    gex_state_t next_q;
    logic scl_d_q;
    logic sda_d_q;
    logic [3:0] cnt_q;
    logic [7:0] shreg_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic more_q;
    logic sda_oe_n_q;
    logic sda_out_q;
    logic [7:0] oe_n_q;
    logic [7:0] pin_out_q;
    logic [7:0] hs_q;
    logic [7:0] ls_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic byte_done;
    logic addr_hit;
    logic wr_fire;
    logic cmd_fire;
    logic [6:0] own_addr;
    logic [7:0] pin_report;
    logic [7:0] rd_byte;

    // Byte returned for a register select; the pointer has no case
    function automatic logic [7:0] read_byte(
        input logic [1:0] sel,
        input gex_regs_t r,
        input logic [7:0] level
    );
        logic [7:0] v;
        v = level;
        case (sel)
            REG_PIN_LEVEL_IN: v = level;
            REG_DRIVE_LEVEL_OUT: v = r.out;
            REG_INPUT_INVERT: v = r.inv;
            REG_PIN_DIRECTION: v = r.dir;
            default: v = level;
        endcase
        return v;
    endfunction

    assign raw = {scl_in, sda_in, addr_strap_bit2, addr_strap_bit1,
                  addr_strap_bit0, port_pin_in};

    gex_sync #(
        .WIDTH($bits(gex_pins_t))
    ) u_sync (
        .clk(sys_clk),
        .d(raw),
        .q(syn)
    );

    // Edge history of the synchronised bus lines; idle-high at reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_d_q <= syn.scl;
            sda_d_q <= syn.sda;
        end
    end

    assign scl_rise = syn.scl & ~scl_d_q;
    assign scl_fall = ~syn.scl & scl_d_q;
    assign bus_start = syn.scl & scl_d_q & sda_d_q & ~syn.sda;
    assign bus_stop = syn.scl & scl_d_q & ~sda_d_q & syn.sda;
    assign byte_done = scl_fall && (cnt_q == BITS_PER_BYTE);
    assign own_addr = {ADDR_UPPER, syn.strap};
    assign addr_hit = (shreg_q[7:1] == own_addr);
    assign wr_fire = (state_q == ST_WDATA) && byte_done;
    assign cmd_fire = (state_q == ST_CMD) && byte_done;

    // Live level, no reset term; inversion masked to input pins
    assign pin_report = syn.pin
        ^ (regs_q.inv & regs_q.dir);
    assign rd_byte = read_byte(ptr_q[1:0], regs_q, pin_report);

    // Bus state machine; start and stop override any state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            next_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            more_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end else if (bus_start) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
        end else if (bus_stop) begin
            state_q <= ST_IDLE;
            sda_oe_n_q <= 1'b1;
        end else begin
            case (state_q)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise && (cnt_q < BITS_PER_BYTE)) begin
                        shreg_q <= {shreg_q[6:0], syn.sda};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        if ((state_q == ST_ADDR) && !addr_hit) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_ACK;
                            sda_oe_n_q <= 1'b0;
                        end
                        if (state_q == ST_ADDR) begin
                            rw_q <= shreg_q[0];
                            next_q <= shreg_q[0] ? ST_RDATA : ST_CMD;
                        end else begin
                            next_q <= ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        state_q <= next_q;
                        if (next_q == ST_RDATA) begin
                            tx_q <= rd_byte;
                            sda_oe_n_q <= rd_byte[7];
                        end else begin
                            sda_oe_n_q <= 1'b1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == LAST_TX_BIT) begin
                            sda_oe_n_q <= 1'b1;
                            state_q <= ST_MACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_n_q <= tx_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        more_q <= ~syn.sda;
                    end else if (scl_fall) begin
                        if (more_q) begin
                            tx_q <= rd_byte;
                            sda_oe_n_q <= rd_byte[7];
                            cnt_q <= 4'h0;
                            state_q <= ST_RDATA;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Command byte goes whole into the pointer; only two bits decode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ptr_q <= POINTER_RST;
        end else if (cmd_fire) begin
            ptr_q <= shreg_q;
        end
    end

    // Register writes; a write aimed at the input register is dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regs_q.out <= DRIVE_LEVEL_OUT_RST;
            regs_q.inv <= INPUT_INVERT_RST;
            regs_q.dir <= PIN_DIRECTION_RST;
        end else if (wr_fire) begin
            case (ptr_q[1:0])
                REG_DRIVE_LEVEL_OUT: regs_q.out <= shreg_q;
                REG_INPUT_INVERT: regs_q.inv <= shreg_q;
                REG_PIN_DIRECTION: regs_q.dir <= shreg_q;
                default: regs_q.out <= regs_q.out;
            endcase
        end
    end

    // Pin drivers lag the registers by one clock, far below bus rate
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            oe_n_q <= PORT_OE_N_RST;
            pin_out_q <= DRIVE_LEVEL_OUT_RST;
            hs_q <= DRIVER_OFF;
            ls_q <= DRIVER_OFF;
        end else begin
            oe_n_q <= regs_q.dir;
            pin_out_q <= regs_q.out;
            hs_q <= ~regs_q.dir & regs_q.out;
            ls_q <= ~regs_q.dir & ~regs_q.out;
        end
    end

    // Open drain: the data output only ever pulls low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end

    assign sda_out = sda_out_q;
    assign sda_oe_n = sda_oe_n_q;
    assign port_pin_out = pin_out_q;
    assign port_pin_oe_n = oe_n_q;
    assign high_side_driver = hs_q;
    assign low_side_driver = ls_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    addr_ack_a: assert property (
        (state_q == ST_ADDR) && byte_done && addr_hit && !bus_start
        && !bus_stop |=> !sda_oe_n_q && (state_q == ST_ACK))
        else $error("matching address not acknowledged");

    addr_miss_a: assert property (
        (state_q == ST_ADDR) && byte_done && !addr_hit && !bus_start
        && !bus_stop |=> sda_oe_n_q && (state_q == ST_IDLE))
        else $error("foreign address was acknowledged");

    rw_dir_a: assert property (
        (state_q == ST_ADDR) && byte_done && addr_hit && !bus_start
        && !bus_stop |=> (rw_q == $past(shreg_q[0]))
        && ((next_q == ST_RDATA) == $past(shreg_q[0])))
        else $error("direction bit not honoured");

    cmd_store_a: assert property (
        cmd_fire && !bus_start && !bus_stop
        |=> ptr_q == $past(shreg_q))
        else $error("command byte not stored in pointer");

    input_wr_a: assert property (
        wr_fire && (ptr_q[1:0] == REG_PIN_LEVEL_IN) |=> $stable(regs_q))
        else $error("write to input register changed state");

    out_readback_a: assert property (
        (state_q == ST_ACK) && scl_fall && (next_q == ST_RDATA)
        && !bus_start && !bus_stop
        && (ptr_q[1:0] == REG_DRIVE_LEVEL_OUT)
        |=> tx_q == regs_q.out)
        else $error("output register read not the written value");

    in_level_read_a: assert property (
        (state_q == ST_ACK) && scl_fall && (next_q == ST_RDATA)
        && !bus_start && !bus_stop && (ptr_q[1:0] == REG_PIN_LEVEL_IN)
        |=> tx_q == $past(syn.pin ^ (regs_q.inv & regs_q.dir)))
        else $error("input read not the inverted pin level");

    reset_val_a: assert property (
        $rose(rst_n) |-> (regs_q.out == DRIVE_LEVEL_OUT_RST)
        && (regs_q.dir == PIN_DIRECTION_RST)
        && (regs_q.inv == INPUT_INVERT_RST) && (state_q == ST_IDLE))
        else $error("registers not at defaults after reset");

    pins_input_a: assert property (
        $rose(rst_n) |-> (port_pin_oe_n == PORT_OE_N_RST)
        && (high_side_driver == DRIVER_OFF)
        && (low_side_driver == DRIVER_OFF))
        else $error("pins not inputs after reset");

    one_driver_a: assert property (
        ((high_side_driver & low_side_driver) == 8'h00)
        && ((high_side_driver | low_side_driver) == ~port_pin_oe_n))
        else $error("driver pair wrong for pin direction");

    dir_drive_a: assert property (
        wr_fire && !bus_start && !bus_stop
        && (ptr_q[1:0] == REG_PIN_DIRECTION)
        |=> ##1 (port_pin_oe_n == $past(shreg_q, 2))
        && (high_side_driver == (~port_pin_oe_n & port_pin_out)))
        else $error("direction write did not reach pins in time");

    wr_loop_a: assert property (
        (state_q == ST_ACK) && (next_q == ST_WDATA) && scl_fall
        && !bus_start && !bus_stop |=> (state_q == ST_WDATA)
        && (cnt_q == 4'h0) && sda_oe_n_q)
        else $error("further data byte not accepted");

    ack_release_a: assert property (
        (state_q == ST_RDATA) && scl_fall && (cnt_q == LAST_TX_BIT)
        && !bus_start && !bus_stop |=> sda_oe_n_q && (state_q == ST_MACK))
        else $error("data line held over master acknowledge");

    write_seen_c: cover property (wr_fire);
    read_more_c: cover property (
        (state_q == ST_MACK) && scl_fall && more_q);
    read_end_c: cover property (
        (state_q == ST_MACK) && scl_fall && !more_q);
    addr_miss_c: cover property (
        (state_q == ST_ADDR) && byte_done && !addr_hit);

endmodule

// ---- core/gex_pkg.sv ----
/*
 * Shared constants, carriers and state encoding for the two-wire
 * eight-bit port expander core.
 * Assumes a single system clock domain; all pins arrive raw and are
 * synchronised inside the core.
 */
package gex_pkg;

    // Register select values (low two bits of the command byte)
    localparam logic [1:0] REG_PIN_LEVEL_IN = 2'h0;
    localparam logic [1:0] REG_DRIVE_LEVEL_OUT = 2'h1;
    localparam logic [1:0] REG_INPUT_INVERT = 2'h2;
    localparam logic [1:0] REG_PIN_DIRECTION = 2'h3;

    // Values after power-up reset
    localparam logic [7:0] DRIVE_LEVEL_OUT_RST = 8'hff;
    localparam logic [7:0] INPUT_INVERT_RST = 8'h00;
    localparam logic [7:0] PIN_DIRECTION_RST = 8'hff;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] PORT_OE_N_RST = 8'hff;
    localparam logic [7:0] DRIVER_OFF = 8'h00;

    // Fixed upper address nibble of the two variants
    localparam logic [3:0] ADDR_UPPER_LOW = 4'h4;
    localparam logic [3:0] ADDR_UPPER_HIGH = 4'h7;

    // Bit counting within one byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // Stored register set
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] inv;
        logic [7:0] out;
    } gex_regs_t;

    // All asynchronous inputs, synchronised together
    typedef struct packed {
        logic scl;
        logic sda;
        logic [2:0] strap;
        logic [7:0] pin;
    } gex_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_MACK
    } gex_state_t;

endpackage

// ---- core/gex_sync.sv ----
/*
 * Two-stage synchroniser for a vector of unrelated level inputs.
 * Assumes each bit is an independent level; no word coherence is
 * promised across bits.
 */
`timescale 1ns/1ns
module gex_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input wire logic clk,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    // No reset, so sampled pin levels carry no invented default
    always_ff @(posedge clk) begin
        meta_q <= d;
        stable_q <= meta_q;
    end

    assign q = stable_q;

endmodule

// ---- verif/gex_i2c_master.sv ----
/*
 * Two-wire bus master model for the port expander core.
 * Assumes the caller drives it from sys_clk falling edges; SDA is an
 * open-drain wire with a pull-up, resolved by the bench.
 */
`timescale 1ns/1ns
module gex_i2c_master (
    // Clock used only for pacing
    input wire logic sys_clk,
    // Resolved data wire
    input wire logic sda_in,
    // Bus clock and data pull-down, low pulls the wire
    output logic scl_o,
    output logic sda_oe_n
);
    // Clock stands high outside frames
    initial begin
        scl_o = 1'b1;
        sda_oe_n = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One 800 ns bit; data sampled late in the high phase so that the
    // slave's synchroniser delay never decides the value
    task automatic bit_io(input logic b, output logic r);
        sda_oe_n = b;
        wait_clk(2);
        scl_o = 1'b1;
        wait_clk(4);
        r = sda_in;
        scl_o = 1'b0;
        wait_clk(2);
    endtask

    // Also serves as repeated start from a low clock
    task automatic start();
        sda_oe_n = 1'b1;
        wait_clk(2);
        scl_o = 1'b1;
        wait_clk(2);
        sda_oe_n = 1'b0;
        wait_clk(2);
        scl_o = 1'b0;
        wait_clk(2);
    endtask

    task automatic stop();
        sda_oe_n = 1'b0;
        wait_clk(2);
        scl_o = 1'b1;
        wait_clk(2);
        sda_oe_n = 1'b1;
        wait_clk(4);
    endtask

    // Address, command and data bytes alike, MSB first
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Master ack low asks for another byte, high ends the read
    task automatic recv(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~mack, r);
    endtask
endmodule

// ---- verif/tb_i2c_gpio_expander_core.sv ----
/*
 * Self-checking bench for the port expander core.
 * Assumes gex_pkg and the core are compiled first; the master model
 * owns the bus, the bench owns straps and external pin levels.
 */
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module tb_i2c_gpio_expander_core import gex_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] strap = 3'h5;
    logic [7:0] ext = 8'h5a;
    logic scl, m_sda_oe_n, sda_out, sda_oe_n, sda;
    logic [7:0] pin_out, pin_oe_n, hi_drv, lo_drv, pin;
    int errors = 0;
    int cmp_count = 0;

    // SDA has a pull-up; a released pin shows the external level
    assign sda = m_sda_oe_n & (sda_oe_n | sda_out);
    assign pin = (~pin_oe_n & pin_out) | (pin_oe_n & ext);

    gex_core i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .port_pin_in(pin),
        .port_pin_out(pin_out), .port_pin_oe_n(pin_oe_n),
        .high_side_driver(hi_drv), .low_side_driver(lo_drv)
    );

    gex_i2c_master i_mst (
        .sys_clk(sys_clk), .sda_in(sda), .scl_o(scl),
        .sda_oe_n(m_sda_oe_n)
    );

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] d,
                      input int n);
        logic a;
        i_mst.start();
        i_mst.send({ADDR_UPPER_LOW, strap, 1'b0}, a);
        `CHK(a, 1'b1)
        i_mst.send(cmd, a);
        `CHK(a, 1'b1)
        for (int i = 0; i < n; i++) begin
            i_mst.send(d[15-8*i -: 8], a);
            `CHK(a, 1'b1)
        end
        i_mst.stop();
    endtask

    // Two bytes: the first acked by the master, the second not
    task automatic rd(input logic [7:0] cmd, output logic [7:0] b0,
                      output logic [7:0] b1);
        logic a;
        i_mst.start();
        i_mst.send({ADDR_UPPER_LOW, strap, 1'b0}, a);
        `CHK(a, 1'b1)
        i_mst.send(cmd, a);
        `CHK(a, 1'b1)
        i_mst.start();
        i_mst.send({ADDR_UPPER_LOW, strap, 1'b1}, a);
        `CHK(a, 1'b1)
        i_mst.recv(1'b1, b0);
        i_mst.recv(1'b0, b1);
        i_mst.stop();
    endtask

    task automatic t_defaults();
        logic [7:0] b0, b1;
        `CHK(pin_oe_n, 8'hff)
        `CHK({hi_drv, lo_drv}, 16'h0000)
        `CHK(sda_oe_n, 1'b1)
        rd(8'h01, b0, b1);
        `CHK(b0, 8'hff)
        rd(8'h02, b0, b1);
        `CHK(b0, 8'h00)
        rd(8'h03, b0, b1);
        `CHK(b0, 8'hff)
        rd(8'h00, b0, b1);
        `CHK(b0, ext)
    endtask

    task automatic t_addr();
        logic a;
        logic [7:0] b0, b1;
        i_mst.start();
        i_mst.send({ADDR_UPPER_HIGH, strap, 1'b0}, a);
        `CHK(a, 1'b0)
        i_mst.stop();
        strap = 3'h2;
        repeat (4) @(negedge sys_clk);
        i_mst.start();
        i_mst.send({ADDR_UPPER_LOW, 3'h5, 1'b0}, a);
        `CHK(a, 1'b0)
        i_mst.stop();
        rd(8'h01, b0, b1);
        `CHK(b0, 8'hff)
        strap = 3'h5;
        repeat (4) @(negedge sys_clk);
    endtask

    // Upper command bits are stored but must not change the decode
    task automatic t_pointer();
        logic a;
        logic [7:0] b0, b1;
        logic [7:0] exp_q[4];
        wr(8'hfd, 16'h9600, 1);
        i_mst.start();
        i_mst.send({ADDR_UPPER_LOW, strap, 1'b1}, a);
        `CHK(a, 1'b1)
        i_mst.recv(1'b0, b0);
        i_mst.stop();
        `CHK(b0, 8'h96)
        exp_q = '{ext, 8'h96, 8'h00, 8'hff};
        for (int s = 0; s < 4; s++) begin
            rd({6'h00, 2'(s)}, b0, b1);
            `CHK(b0, exp_q[s])
        end
    endtask

    task automatic t_input_ro();
        logic [7:0] b0, b1;
        ext = 8'h3c;
        wr(8'h00, 16'h0000, 1);
        rd(8'h00, b0, b1);
        `CHK(b0, 8'h3c)
        rd(8'h01, b0, b1);
        `CHK(b0, 8'h96)
    endtask

    task automatic t_port();
        logic [7:0] b0, b1;
        ext = 8'ha5;
        wr(8'h01, 16'h113c, 2);
        wr(8'h03, 16'hf000, 1);
        `CHK(pin_oe_n, 8'hf0)
        `CHK(hi_drv, 8'h0c)
        `CHK(lo_drv, 8'h03)
        `CHK(pin_out & ~pin_oe_n, 8'h0c)
        rd(8'h00, b0, b1);
        `CHK(b0, 8'hac)
        rd(8'h01, b0, b1);
        `CHK(b0, 8'h3c)
    endtask

    // Output pins must report raw levels even with inversion set
    task automatic t_invert();
        logic [7:0] b0, b1;
        wr(8'h02, 16'hff00, 1);
        rd(8'h00, b0, b1);
        `CHK(b0, 8'h5c)
        `CHK(b1, 8'h5c)
        wr(8'h02, 16'h3000, 1);
        rd(8'h00, b0, b1);
        `CHK(b0, 8'h9c)
    endtask

    // Reset in the middle of a frame must clear the bus machine too
    task automatic t_midreset();
        logic a;
        i_mst.start();
        i_mst.send({ADDR_UPPER_LOW, strap, 1'b0}, a);
        `CHK(a, 1'b1)
        do_reset();
        t_defaults();
    endtask

    initial begin
        do_reset();
        t_defaults();
        t_addr();
        t_pointer();
        t_input_ro();
        t_port();
        t_invert();
        t_midreset();
        tally_and_finish();
    end

    // Whole run is near 9200 cycles; over six times that means a hang
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        tally_and_finish();
    end
endmodule
